// ===== hw/can_irq_pkg.sv
// Package: offsets, bit positions, reset values and carriers for the flags
package can_irq_pkg;

   // Register offsets on the serial register port
   localparam logic [15:0] FLAGS_OFS   = 16'h1050;
   localparam logic [15:0] ENABLE_OFS  = 16'h1054;
   localparam logic [15:0] LINESEL_OFS = 16'h1058;

   // Number of flags held by this block
   localparam int FLAG_W = 14;

   // Bit positions of the flags in the status word
   localparam int POS_TXEVQ_WM   = 13;
   localparam int POS_TXEVQ_NEW  = 12;
   localparam int POS_TXQ_EMPTY  = 11;
   localparam int POS_CANCEL     = 10;
   localparam int POS_XMIT       = 9;
   localparam int POS_HIGH_PRIO  = 8;
   localparam int POS_RXQ1_LOST  = 7;
   localparam int POS_RXQ1_FULL  = 6;
   localparam int POS_RXQ1_WM    = 5;
   localparam int POS_RXQ1_NEW   = 4;
   localparam int POS_RXQ0_LOST  = 3;
   localparam int POS_RXQ0_FULL  = 2;
   localparam int POS_RXQ0_WM    = 1;
   localparam int POS_RXQ0_NEW   = 0;

   // Reset values
   localparam logic [13:0] FLAGS_RST   = 14'h0000;
   localparam logic [13:0] ENABLE_RST  = 14'h0000;
   localparam logic [13:0] LINESEL_RST = 14'h0000;
   localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

   // Flag word, bit 13 first
   typedef struct packed {
      logic txevq_watermark_flag;
      logic txevq_new_entry_flag;
      logic txq_empty_flag;
      logic cancel_done_flag;
      logic xmit_done_flag;
      logic high_prio_rx_flag;
      logic rxq1_lost_flag;
      logic rxq1_full_flag;
      logic rxq1_watermark_flag;
      logic rxq1_new_msg_flag;
      logic rxq0_lost_flag;
      logic rxq0_full_flag;
      logic rxq0_watermark_flag;
      logic rxq0_new_msg_flag;
   } flag_vec_t;

   // One register access from the serial port decoder
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [31:0] wdata;
   } reg_req_t;

endpackage

// ===== hw/sticky_flag_bank.sv
// Bank of sticky flags: hardware sets, software clears, set wins
`timescale 1ns/1ps

module sticky_flag_bank
   import can_irq_pkg::*;
#(
   parameter int          WIDTH = FLAG_W,
   parameter logic [13:0] RST   = FLAGS_RST
) (
   // Clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             rstn_in,
   // Set and clear vectors, one cycle each
   input  wire logic [WIDTH-1:0] set_in,
   input  wire logic [WIDTH-1:0] clr_in,
   // Held flags
   output logic      [WIDTH-1:0] flags_out
);

   logic [WIDTH-1:0] flags_reg;
   logic [WIDTH-1:0] flags_next;

   // A set in the clearing cycle survives, so no event is lost
   always_comb begin
      flags_next = (flags_reg & ~clr_in) | set_in;
   end

   // Flag storage
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         flags_reg <= RST[WIDTH-1:0];
      end else begin
         flags_reg <= flags_next;
      end
   end

   assign flags_out = flags_reg;

endmodule

// ===== hw/can_fifo_interrupt_flags.sv
// Lower fourteen interrupt flags of the CAN FD controller with routing
`timescale 1ns/1ps

// Contract
// - Bit 13 set when transmit event queue fill reaches its watermark.
// - Bit 12 set whenever an element enters the transmit event queue.
// - Bit 11 set while the transmit queue holds no pending message.
// - Bit 10 set when a requested transmit cancellation has finished.
// - Bit 9 set when a frame transmission finishes successfully.
// - Bit 8 set when a high priority message is accepted.
// - Bit 7 set on a lost queue-one message or zero-size store.
// - Bit 6 set while receive queue one is full.
// - Bit 5 set when receive queue one fill reaches its watermark.
// - Bit 4 set whenever a message is written into receive queue one.
// - Bit 3 set on a lost queue-zero message or zero-size store.
// - Bit 2 set while receive queue zero is full.
// - Bit 1 set when receive queue zero fill reaches its watermark.
// - Bit 0 set whenever a message is written into receive queue zero.
// - A flag drives an interrupt line only when its enable bit is one.
// - Line-select bit zero routes to line zero, one to line one.
module can_fifo_interrupt_flags
   import can_irq_pkg::*;
#(
   parameter int LVL_W = 7
) (
   // Clock and reset
   input  wire logic             clk_sys_in,
   input  wire logic             rstn_in,
   // Register access from the serial port decoder
   input  wire reg_req_t         reg_req_in,
   output logic      [31:0]      reg_rdata_out,
   output logic                  reg_rvalid_out,
   // Transmit handler events, one-cycle pulses
   input  wire logic             txevq_write_in,
   input  wire logic             cancel_done_in,
   input  wire logic             xmit_done_in,
   // Transmit handler levels
   input  wire logic             txq_empty_in,
   input  wire logic [LVL_W-1:0] txevq_fill_in,
   input  wire logic [LVL_W-1:0] txevq_wm_in,
   // Receive handler events, one-cycle pulses, bit n for queue n
   input  wire logic             high_prio_rx_in,
   input  wire logic [1:0]       rxq_write_in,
   input  wire logic [1:0]       rxq_drop_in,
   input  wire logic [1:0]       rxq_store_try_in,
   // Receive handler levels, bit n for queue n
   input  wire logic [1:0]       rxq_zero_size_in,
   input  wire logic [1:0]       rxq_full_in,
   input  wire logic [LVL_W-1:0] rxq0_fill_in,
   input  wire logic [LVL_W-1:0] rxq0_wm_in,
   input  wire logic [LVL_W-1:0] rxq1_fill_in,
   input  wire logic [LVL_W-1:0] rxq1_wm_in,
   // Flag word and the two module interrupt lines
   output flag_vec_t             flags_out,
   output logic                  int_line0_out,
   output logic                  int_line1_out
);

   flag_vec_t   set_vec;
   logic [13:0] clr_vec;
   logic [13:0] flags_raw;
   logic [13:0] enable_reg;
   logic [13:0] linesel_reg;
   logic [13:0] active;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        rvalid_reg;
   logic        int0_reg;
   logic        int1_reg;
   logic        wr_flags;
   logic        wr_enable;
   logic        wr_linesel;

   // Watermark compare; a watermark of zero leaves the flag disabled
   function automatic logic wm_reached(input logic [LVL_W-1:0] fill,
                                       input logic [LVL_W-1:0] wm);
      wm_reached = (wm != '0) && (fill >= wm);
   endfunction

   // Word to 32 bits with the unused upper field reading zero
   function automatic logic [31:0] widen(input logic [13:0] v);
      widen = {18'h00000, v};
   endfunction

   // Write strobe for one register; only whole-word writes exist here
   function automatic logic wr_hit(input reg_req_t    req,
                                   input logic [15:0] ofs);
      wr_hit = req.wr && (req.addr == ofs);
   endfunction

   // A drop, or a store into a queue sized zero, loses the message
   function automatic logic lost_event(input logic drop,
                                       input logic store_try,
                                       input logic zero_size);
      lost_event = drop || (store_try && zero_size);
   endfunction

   // Any enabled flag whose select matches the wanted line
   function automatic logic line_req(input logic [13:0] act,
                                     input logic [13:0] sel);
      line_req = |(act & sel);
   endfunction

   // Address decode, one strobe per stored register
   assign wr_flags   = wr_hit(reg_req_in, FLAGS_OFS);
   assign wr_enable  = wr_hit(reg_req_in, ENABLE_OFS);
   assign wr_linesel = wr_hit(reg_req_in, LINESEL_OFS);

   // Set conditions from the handlers; level ones re-set while true
   always_comb begin
      set_vec = '0;
      set_vec.txevq_watermark_flag = wm_reached(txevq_fill_in, txevq_wm_in);
      set_vec.txevq_new_entry_flag = txevq_write_in;
      set_vec.txq_empty_flag = txq_empty_in;
      set_vec.cancel_done_flag = cancel_done_in;
      set_vec.xmit_done_flag = xmit_done_in;
      set_vec.high_prio_rx_flag = high_prio_rx_in;
      // queue one lost, zero-size store included
      set_vec.rxq1_lost_flag = lost_event(rxq_drop_in[1], rxq_store_try_in[1],
                                          rxq_zero_size_in[1]);
      set_vec.rxq1_full_flag = rxq_full_in[1];
      set_vec.rxq1_watermark_flag = wm_reached(rxq1_fill_in, rxq1_wm_in);
      set_vec.rxq1_new_msg_flag = rxq_write_in[1];
      // queue zero lost, zero-size store included
      set_vec.rxq0_lost_flag = lost_event(rxq_drop_in[0], rxq_store_try_in[0],
                                          rxq_zero_size_in[0]);
      set_vec.rxq0_full_flag = rxq_full_in[0];
      set_vec.rxq0_watermark_flag = wm_reached(rxq0_fill_in, rxq0_wm_in);
      set_vec.rxq0_new_msg_flag = rxq_write_in[0];
   end

   assign clr_vec = wr_flags ? reg_req_in.wdata[13:0] : 14'h0000;

   // Sticky storage; a level condition still true re-sets at once,
   // so a cleared level flag reads zero only once it has gone away
   sticky_flag_bank #(
      .WIDTH (FLAG_W),
      .RST   (FLAGS_RST)
   ) u_flags (
      .clk_sys_in (clk_sys_in),
      .rstn_in    (rstn_in),
      .set_in     (set_vec),
      .clr_in     (clr_vec),
      .flags_out  (flags_raw)
   );

   assign flags_out = flag_vec_t'(flags_raw);

   // Interrupt enable register
   // Only bits 13:0 are kept; upper enables belong to other flags
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         enable_reg <= ENABLE_RST;
      end else if (wr_enable) begin
         enable_reg <= reg_req_in.wdata[13:0];
      end
   end

   // Interrupt line select register
   // A change of select moves a pending line at the next edge
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         linesel_reg <= LINESEL_RST;
      end else if (wr_linesel) begin
         linesel_reg <= reg_req_in.wdata[13:0];
      end
   end

   // only enabled flags can raise a line
   assign active = flags_raw & enable_reg;

   // Line outputs come from flops, one cycle behind the flags
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         int0_reg <= 1'b0;
         int1_reg <= 1'b0;
      end else begin
         // select zero feeds line zero, one feeds line one
         int0_reg <= line_req(active, ~linesel_reg);
         int1_reg <= line_req(active, linesel_reg);
      end
   end

   assign int_line0_out = int0_reg;
   assign int_line1_out = int1_reg;

   // Read mux; unmapped offsets read zero rather than stalling
   always_comb begin
      case (reg_req_in.addr)
         FLAGS_OFS:   rdata_next = widen(flags_raw);
         ENABLE_OFS:  rdata_next = widen(enable_reg);
         LINESEL_OFS: rdata_next = widen(linesel_reg);
         default:     rdata_next = RDATA_RST;
      endcase
   end

   // Read data is captured on the request edge and held until the next
   always_ff @(posedge clk_sys_in) begin
      if (!rstn_in) begin
         rdata_reg  <= RDATA_RST;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= reg_req_in.rd;
         if (reg_req_in.rd) begin
            rdata_reg <= rdata_next;
         end
      end
   end

   assign reg_rdata_out  = rdata_reg;
   assign reg_rvalid_out = rvalid_reg;

endmodule

// ===== testbench/can_flags_properties.sv
// Port checks for the flag block
`timescale 1ns/1ps
module can_flags_properties
   import can_irq_pkg::*;
#(
   parameter int LVL_W = 7
) (
   // Clock, reset and register port
   input wire logic             clk_sys_in,
   input wire logic             rstn_in,
   input wire reg_req_t         reg_req_in,
   input wire logic             reg_rvalid_out,
   // Handler inputs
   input wire logic             xmit_done_in,
   input wire logic             txq_empty_in,
   input wire logic [1:0]       rxq_write_in,
   input wire logic [1:0]       rxq_drop_in,
   input wire logic [1:0]       rxq_store_try_in,
   input wire logic [1:0]       rxq_zero_size_in,
   input wire logic [LVL_W-1:0] rxq0_fill_in,
   input wire logic [LVL_W-1:0] rxq0_wm_in,
   // Flag word
   input wire flag_vec_t        flags_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rstn_in);
   logic        clr;
   logic [13:0] fv;
   // Only a flag register write may lower a flag
   assign clr = reg_req_in.wr && reg_req_in.addr == FLAGS_OFS;
   assign fv = flags_out;
   sequence s_read;
      reg_req_in.rd ##1 reg_rvalid_out;
   endsequence
   chk_read_answer: assert property (
      reg_req_in.rd |-> s_read) else $error("read not answered");
   chk_flags_sticky: assert property (
      !clr |=> (fv & $past(fv)) == $past(fv)) else $error("flag fell");
   chk_rx0_new: assert property (
      rxq_write_in[0] |=> flags_out.rxq0_new_msg_flag)
      else $error("queue zero new flag missing");
   chk_rx1_new: assert property (
      rxq_write_in[1] |=> flags_out.rxq1_new_msg_flag)
      else $error("queue one new flag missing");
   chk_txq_empty: assert property (
      txq_empty_in |=> flags_out.txq_empty_flag) else $error("empty flag");
   chk_xmit_done: assert property (
      xmit_done_in |=> flags_out.xmit_done_flag) else $error("done flag");
   chk_rx0_lost: assert property (
      rxq_drop_in[0] || rxq_store_try_in[0] && rxq_zero_size_in[0]
      |=> flags_out.rxq0_lost_flag) else $error("queue zero lost flag");
   chk_rx1_lost: assert property (
      rxq_drop_in[1] || rxq_store_try_in[1] && rxq_zero_size_in[1]
      |=> flags_out.rxq1_lost_flag) else $error("queue one lost flag");
   chk_rx0_wmark: assert property (
      rxq0_wm_in != '0 && rxq0_fill_in >= rxq0_wm_in
      |=> flags_out.rxq0_watermark_flag) else $error("watermark flag");
endmodule

bind can_fifo_interrupt_flags can_flags_properties #(.LVL_W(LVL_W)) u_chk (
   .clk_sys_in, .rstn_in, .reg_req_in, .reg_rvalid_out, .xmit_done_in,
   .txq_empty_in, .rxq_write_in, .rxq_drop_in, .rxq_store_try_in,
   .rxq_zero_size_in, .rxq0_fill_in, .rxq0_wm_in, .flags_out);

// ===== testbench/host_model.sv
// Host side model: register reads and write-one-to-clear writes
`timescale 1ns/1ps
module host_model
   import can_irq_pkg::*;
(
   // Clock and answer
   input  wire logic        clk_sys_in,
   input  wire logic [31:0] reg_rdata_out,
   input  wire logic        reg_rvalid_out,
   // Request
   output reg_req_t         reg_req_in
);
   initial reg_req_in = '0;
   // clear by ones
   // Released bus shows inverted values so nothing stale looks current
   task automatic xfer(input logic w, input logic [15:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic v);
      @(posedge clk_sys_in);
      #1;
      reg_req_in = '{wr: w, rd: !w, addr: a, wdata: d};
      @(posedge clk_sys_in);
      #1;
      reg_req_in = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      q = reg_rdata_out;
      v = reg_rvalid_out;
   endtask
endmodule

// ===== testbench/can_fifo_interrupt_flags_test.sv
// Self-checking bench for the fourteen flags and their routing
`timescale 1ns/1ps
module can_fifo_interrupt_flags_test;
   import can_irq_pkg::*;
   logic        clk_sys_in, rstn_in, reg_rvalid_out, v;
   logic        txevq_write_in, cancel_done_in, xmit_done_in, txq_empty_in;
   logic        high_prio_rx_in, int_line0_out, int_line1_out;
   logic [6:0]  txevq_fill_in, txevq_wm_in, rxq0_fill_in, rxq0_wm_in;
   logic [6:0]  rxq1_fill_in, rxq1_wm_in;
   logic [1:0]  rxq_write_in, rxq_drop_in, rxq_store_try_in;
   logic [1:0]  rxq_zero_size_in, rxq_full_in;
   logic [31:0] reg_rdata_out, q;
   reg_req_t    reg_req_in;
   flag_vec_t   flags_out;
   int          miscompares, n_compared;

   can_fifo_interrupt_flags DUT (.clk_sys_in, .rstn_in, .reg_req_in,
      .reg_rdata_out, .reg_rvalid_out, .txevq_write_in, .cancel_done_in,
      .xmit_done_in, .txq_empty_in, .txevq_fill_in, .txevq_wm_in,
      .high_prio_rx_in, .rxq_write_in, .rxq_drop_in, .rxq_store_try_in,
      .rxq_zero_size_in, .rxq_full_in, .rxq0_fill_in, .rxq0_wm_in,
      .rxq1_fill_in, .rxq1_wm_in, .flags_out, .int_line0_out, .int_line1_out);
   host_model u_host (.clk_sys_in, .reg_rdata_out, .reg_rvalid_out,
      .reg_req_in);

   task automatic chk(input string what, input logic [31:0] got, exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic rd(input logic [15:0] a);
      u_host.xfer(1'b0, a, 32'h0, q, v);
      chk("read valid", {31'h0, v}, 32'h1);
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      u_host.xfer(1'b1, a, d, q, v);
   endtask
   task automatic tick();
      @(posedge clk_sys_in);
      #1;
   endtask
   // Cause of flag i; fill levels sit one below their watermark when idle
   task automatic drive(input int i, input logic s);
      case (i)
         13: txevq_fill_in = s ? 7'h05 : 7'h04;
         12: txevq_write_in = s;
         11: txq_empty_in = s;
         10: cancel_done_in = s;
         9: xmit_done_in = s;
         8: high_prio_rx_in = s;
         7: begin
            rxq_zero_size_in[1] = s;
            rxq_store_try_in[1] = s;
         end
         6: rxq_full_in[1] = s;
         5: rxq1_fill_in = s ? 7'h05 : 7'h04;
         4: rxq_write_in[1] = s;
         3: rxq_drop_in[0] = s;
         2: rxq_full_in[0] = s;
         1: rxq0_fill_in = s ? 7'h05 : 7'h04;
         default: rxq_write_in[0] = s;
      endcase
   endtask
   task automatic fire(input int i);
      tick();
      drive(i, 1'b1);
      tick();
      drive(i, 1'b0);
   endtask

   task automatic t_reset_values();
      rd(FLAGS_OFS);
      chk("flags at reset", q, 32'h0);
      rd(ENABLE_OFS);
      chk("enable at reset", q, 32'h0);
      rd(LINESEL_OFS);
      chk("line select at reset", q, 32'h0);
      wr(16'h1060, 32'hffff_ffff);
      rd(16'h1060);
      chk("unmapped", q, 32'h0);
   endtask
   task automatic t_each_flag();
      for (int i = 0; i < FLAG_W; i++) begin
         fire(i);
         rd(FLAGS_OFS);
         chk("flag set", q, 32'h1 << i);
         wr(FLAGS_OFS, 32'h1 << i);
         rd(FLAGS_OFS);
         chk("flag cleared", q, 32'h0);
      end
   endtask
   // Second cause of each lost flag, and a store into a sized queue
   task automatic t_lost_paths();
      tick();
      rxq_store_try_in[0] = 1'b1;
      tick();
      rxq_store_try_in[0] = 1'b0;
      rd(FLAGS_OFS);
      chk("store into sized queue", q, 32'h0);
      tick();
      rxq_drop_in[1] = 1'b1;
      {rxq_store_try_in[0], rxq_zero_size_in[0]} = 2'b11;
      tick();
      rxq_drop_in[1] = 1'b0;
      {rxq_store_try_in[0], rxq_zero_size_in[0]} = 2'b00;
      rd(FLAGS_OFS);
      chk("lost by both paths", q, 32'h0000_0088);
      chk("queue zero lost", {31'h0, q[3]}, 32'h1);
      wr(FLAGS_OFS, 32'h0000_0088);
      rd(FLAGS_OFS);
      chk("lost flags cleared", q, 32'h0);
   endtask
   task automatic t_routing();
      wr(ENABLE_OFS, 32'h0000_0001);
      fire(0);
      tick();
      chk("line0", {31'h0, int_line0_out}, 32'h1);
      chk("line1", {31'h0, int_line1_out}, 32'h0);
      wr(LINESEL_OFS, 32'h0000_0001);
      tick();
      chk("line0 moved", {31'h0, int_line0_out}, 32'h0);
      chk("line1 routed", {31'h0, int_line1_out}, 32'h1);
      wr(ENABLE_OFS, 32'h0);
      tick();
      chk("line1 masked", {31'h0, int_line1_out}, 32'h0);
      // Set in the clearing cycle must win
      fork
         fire(0);
         wr(FLAGS_OFS, 32'h1);
      join
      rd(FLAGS_OFS);
      chk("set beats clear", q, 32'h1);
   endtask

   task automatic final_report();
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      clk_sys_in = 1'b0;
      forever #5 clk_sys_in = ~clk_sys_in;
   end
   // Hang guard
   initial begin
      #200000;
      miscompares++;
      final_report();
   end
   initial begin
      rstn_in = 1'b0;
      {txevq_write_in, cancel_done_in, xmit_done_in, txq_empty_in} = '0;
      {high_prio_rx_in, rxq_write_in, rxq_drop_in, rxq_store_try_in} = '0;
      {rxq_zero_size_in, rxq_full_in} = '0;
      {txevq_fill_in, rxq0_fill_in, rxq1_fill_in} = {3{7'h04}};
      {txevq_wm_in, rxq0_wm_in, rxq1_wm_in} = {3{7'h05}};
      repeat (4) @(posedge clk_sys_in);
      #1;
      rstn_in = 1'b1;
      t_reset_values();
      t_each_flag();
      t_lost_paths();
      t_routing();
      final_report();
   end
endmodule
